/* File: rtl/act_pkg.sv */
/*
 * Constants and types for the converter control and test register bank.
 * Assumes a core sample clock and a three-wire serial host on its own clock.
 */
// Operation
// - Read-only identification byte, fixed code
// - Speed grade read in bits five to four
// - Power mode 00 normal, 01 powered down
// - Mode 10 stops datapath, outputs stay on
// - Mode 11 holds datapath and serializer reset
// - Status bit seven shows PLL lock
// - Test codes 0-3: normal, mid, +full, -full
// - Checkerboard, long PN, toggle, ramp codes
// - Code 1000 plays four user words
// - Repeat bit 0: user words loop forever
// - Repeat bit 1: words once, then zeros
// - Repeat bit ignored outside user mode
// - Test bit five holds long PN reset
// - Signed six-bit offset added to samples
// - Writes shadowed until transfer, self-clearing
package act_pkg;

    // ----------------------------------------------------------------
    // Register addresses (13-bit serial address space)
    // ----------------------------------------------------------------
    localparam logic [12:0] ACT_ADDR_CHIP_IDENTITY   = 13'h0001;
    localparam logic [12:0] ACT_ADDR_GRADE     = 13'h0002;
    localparam logic [12:0] ACT_ADDR_POWER     = 13'h0008;
    localparam logic [12:0] ACT_ADDR_PLL       = 13'h000A;
    localparam logic [12:0] ACT_ADDR_TEST      = 13'h000D;
    localparam logic [12:0] ACT_ADDR_OFFSET    = 13'h0010;
    localparam logic [12:0] ACT_ADDR_TRANSFER  = 13'h00FF;

    // ----------------------------------------------------------------
    // Field positions, masks and reset values
    // ----------------------------------------------------------------
    localparam int          ACT_GRADE_LSB      = 4;
    localparam int          ACT_PLL_LOCK_BIT   = 7;
    localparam int          ACT_TEST_ONCE_BIT  = 7;
    localparam int          ACT_TEST_PNRST_BIT = 5;
    localparam logic [7:0]  ACT_POWER_RESET    = 8'h80;
    localparam logic [7:0]  ACT_TEST_RESET     = 8'h00;
    localparam logic [7:0]  ACT_TEST_WMASK     = 8'hBF;
    localparam logic [5:0]  ACT_OFFSET_RESET   = 6'h00;
    localparam logic [7:0]  ACT_TRANSFER_GO    = 8'h01;

    // ----------------------------------------------------------------
    // Power modes and test generator codes
    // ----------------------------------------------------------------
    localparam logic [1:0]  ACT_PWR_NORMAL     = 2'h0;
    localparam logic [1:0]  ACT_PWR_DOWN       = 2'h1;
    localparam logic [1:0]  ACT_PWR_STANDBY    = 2'h2;
    localparam logic [1:0]  ACT_PWR_DPRESET    = 2'h3;
    localparam logic [3:0]  ACT_TG_OFF         = 4'h0;
    localparam logic [3:0]  ACT_TG_MID         = 4'h1;
    localparam logic [3:0]  ACT_TG_POSFS       = 4'h2;
    localparam logic [3:0]  ACT_TG_NEGFS       = 4'h3;
    localparam logic [3:0]  ACT_TG_CHECKER     = 4'h4;
    localparam logic [3:0]  ACT_TG_PN_LONG     = 4'h5;
    localparam logic [3:0]  ACT_TG_TOGGLE      = 4'h7;
    localparam logic [3:0]  ACT_TG_USER        = 4'h8;
    localparam logic [3:0]  ACT_TG_RAMP        = 4'hF;

    // ----------------------------------------------------------------
    // Serial frame and generator constants
    // ----------------------------------------------------------------
    localparam logic [3:0]  ACT_INSTR_LAST     = 4'hF;
    localparam logic [3:0]  ACT_BYTE_LAST      = 4'h7;
    localparam logic [22:0] ACT_PN_SEED        = 23'h7FFFFF;
    localparam int          ACT_PN_TAP         = 17;

    typedef enum logic {ACT_PH_INSTR, ACT_PH_DATA} act_phase_t;

    // Configuration image, held both as shadow and as active copy
    typedef struct packed {
        logic [1:0] power;
        logic [7:0] test;
        logic [5:0] offset;
    } act_cfg_t;

endpackage

/* File: rtl/act_regs.sv */
/*
 * Shadowed register bank with serial host port, test pattern generator,
 * offset adder and output sample FIFO.
 * Assumes sclk_in runs only inside frames and the sample clock runs freely.
 */
`timescale 1ns/1ps
`default_nettype none

// --------------------------------------------------------------------
// Sample FIFO
// --------------------------------------------------------------------
module act_fifo
    import act_pkg::*;
#(
    parameter int WIDTH = 12,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_in,
    input  wire logic             nrst_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic      [WIDTH-1:0] out_data_out
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW:0]      wp_q;
    logic [PW:0]      wp_d;
    logic [PW:0]      rp_q;
    logic [PW:0]      rp_d;
    logic             full;
    logic             empty;
    logic             push;
    logic             pop;

    // Honest full and empty from extended pointers
    assign empty         = (wp_q == rp_q);
    assign full          = (wp_q[PW] != rp_q[PW]) && (wp_q[PW-1:0] == rp_q[PW-1:0]);
    assign in_ready_out  = !full;
    assign out_valid_out = !empty;
    assign out_data_out  = mem_q[rp_q[PW-1:0]];
    assign push          = in_valid_in && !full;
    assign pop           = out_ready_in && !empty;

    // Pointer next values
    always_comb begin
        wp_d = push ? wp_q + 1'b1 : wp_q;
        rp_d = pop ? rp_q + 1'b1 : rp_q;
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
        end
    end

    // Storage, written only on push
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_q[wp_q[PW-1:0]] <= in_data_in;
        end
    end
endmodule // act_fifo

// --------------------------------------------------------------------
// Register bank top
// --------------------------------------------------------------------
module act_regs
    import act_pkg::*;
#(
    parameter int         DATA_W     = 12,
    parameter int         FIFO_DEPTH = 16,
    parameter logic [7:0] CHIP_IDENTITY    = 8'h5A,  // Arbitrary value
    parameter logic [1:0] GRADE      = 2'h2    // Arbitrary value
) (
    input  wire logic                core_clk_in,
    input  wire logic                nrst_in,
    // Serial host port
    input  wire logic                sclk_in,
    input  wire logic                csb_n_in,
    input  wire logic                sdio_in,
    output logic                     sdio_out,
    output logic                     sdio_oe_out,
    // Status and power controls
    input  wire logic                pll_locked_in,
    output logic                     power_down_out,
    output logic                     dp_clk_en_out,
    output logic                     dp_reset_out,
    output logic                     serial_reset_out,
    output logic                     outputs_en_out,
    // Sample stream
    input  wire logic                sample_valid_in,
    output logic                     sample_ready_out,
    input  wire logic [DATA_W-1:0]   sample_data_in,
    input  wire logic [4*DATA_W-1:0] user_pattern_in,
    output logic                     out_valid_out,
    input  wire logic                out_ready_in,
    output logic      [DATA_W-1:0]   out_data_out
);
    // ----------------------------------------------------------------
    // Core reset register, also resets the serial side asynchronously
    // ----------------------------------------------------------------
    logic rst_n_q;

    always_ff @(posedge core_clk_in) begin
        rst_n_q <= nrst_in;
    end

    // ----------------------------------------------------------------
    // Serial frame logic (sclk domain, cleared while chip select high)
    // ----------------------------------------------------------------
    act_phase_t  ph_q, ph_d;
    logic [3:0]  cnt_q, cnt_d;
    logic [15:0] ins_q, ins_d;
    logic [12:0] adr_q, adr_d;
    logic        rnw_q, rnw_d;
    logic [7:0]  dsh_q, dsh_d;
    logic [7:0]  rd_q, rd_d;
    logic        oe_q, oe_d;
    logic        wr_fire;
    logic [7:0]  wr_byte;
    act_cfg_t    sh_q, sh_d;
    logic        xfer_q, xfer_d;
    logic        req_q, req_d;
    logic        ack_s1_q, ack_s2_q;
    logic        pll_s1_q, pll_s2_q;
    logic        ack_q;

    // Readback of shadow image and read-only fields
    function automatic logic [7:0] rd_mux(input logic [12:0] a);
        logic [7:0] r;
        r = 8'h00;
        case (a)
            ACT_ADDR_CHIP_IDENTITY:  r = CHIP_IDENTITY;
            ACT_ADDR_GRADE:    r = {2'h0, GRADE, 4'h0};
            ACT_ADDR_POWER:    r = ACT_POWER_RESET | {6'h00, sh_q.power};
            ACT_ADDR_PLL:      r = {pll_s2_q, 7'h00};
            ACT_ADDR_TEST:     r = sh_q.test;
            ACT_ADDR_OFFSET:   r = {2'h0, sh_q.offset};
            ACT_ADDR_TRANSFER: r = {7'h00, xfer_q};
            default:           r = 8'h00;
        endcase
        return r;
    endfunction

    assign wr_fire     = (ph_q == ACT_PH_DATA) && (cnt_q == ACT_BYTE_LAST) && !rnw_q;
    assign wr_byte     = {dsh_q[6:0], sdio_in};
    assign sdio_out    = rd_q[7];
    assign sdio_oe_out = oe_q;

    // Instruction word then data bytes, MSB first, address decrements
    always_comb begin
        ph_d  = ph_q;
        cnt_d = cnt_q + 4'h1;
        ins_d = ins_q;
        adr_d = adr_q;
        rnw_d = rnw_q;
        dsh_d = {dsh_q[6:0], sdio_in};
        rd_d  = {rd_q[6:0], 1'b0};
        oe_d  = oe_q;
        case (ph_q)
            ACT_PH_INSTR: begin
                ins_d = {ins_q[14:0], sdio_in};
                if (cnt_q == ACT_INSTR_LAST) begin
                    ph_d  = ACT_PH_DATA;
                    cnt_d = 4'h0;
                    rnw_d = ins_q[14];
                    adr_d = {ins_q[11:0], sdio_in};
                    rd_d  = rd_mux({ins_q[11:0], sdio_in});
                    oe_d  = ins_q[14];
                end
            end
            ACT_PH_DATA: begin
                if (cnt_q == ACT_BYTE_LAST) begin
                    cnt_d = 4'h0;
                    adr_d = adr_q - 13'h0001;
                    rd_d  = rd_mux(adr_q - 13'h0001);
                end
            end
            default: begin
                ph_d = ACT_PH_INSTR;
            end
        endcase
    end

    always_ff @(posedge sclk_in or posedge csb_n_in or negedge rst_n_q) begin
        if (csb_n_in || !rst_n_q) begin
            ph_q  <= ACT_PH_INSTR;
            cnt_q <= 4'h0;
            ins_q <= 16'h0000;
            adr_q <= 13'h0000;
            rnw_q <= 1'b0;
            dsh_q <= 8'h00;
            rd_q  <= 8'h00;
            oe_q  <= 1'b0;
        end else begin
            ph_q  <= ph_d;
            cnt_q <= cnt_d;
            ins_q <= ins_d;
            adr_q <= adr_d;
            rnw_q <= rnw_d;
            dsh_q <= dsh_d;
            rd_q  <= rd_d;
            oe_q  <= oe_d;
        end
    end

    // Shadow registers and transfer bit; a set while the bit is still high is ignored
    always_comb begin
        sh_d   = sh_q;
        xfer_d = xfer_q;
        req_d  = req_q;
        if (xfer_q && (ack_s2_q == req_q)) begin
            xfer_d = 1'b0;
        end
        if (wr_fire) begin
            case (adr_q)
                ACT_ADDR_POWER:  sh_d.power  = wr_byte[1:0];
                ACT_ADDR_TEST:   sh_d.test   = wr_byte & ACT_TEST_WMASK;
                ACT_ADDR_OFFSET: sh_d.offset = wr_byte[5:0];
                ACT_ADDR_TRANSFER: begin
                    if (wr_byte == ACT_TRANSFER_GO && !xfer_q) begin
                        xfer_d = 1'b1;
                        req_d  = !req_q;
                    end
                end
                default: sh_d = sh_q;
            endcase
        end
    end

    always_ff @(posedge sclk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            sh_q     <= '{power: ACT_PWR_NORMAL, test: ACT_TEST_RESET,
                          offset: ACT_OFFSET_RESET};
            xfer_q   <= 1'b0;
            req_q    <= 1'b0;
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
            pll_s1_q <= 1'b0;
            pll_s2_q <= 1'b0;
        end else begin
            sh_q     <= sh_d;
            xfer_q   <= xfer_d;
            req_q    <= req_d;
            ack_s1_q <= ack_q;
            ack_s2_q <= ack_s1_q;
            pll_s1_q <= pll_locked_in;
            pll_s2_q <= pll_s1_q;
        end
    end

    // ----------------------------------------------------------------
    // Transfer handshake into the core domain
    // ----------------------------------------------------------------
    logic     req_s1_q, req_s2_q;
    logic     ack_d;
    act_cfg_t act_q, act_d;

    // Shadow image is copied once the request toggle arrives; shadow writes are not blocked while it is in flight
    always_comb begin
        act_d = act_q;
        ack_d = ack_q;
        if (req_s2_q != ack_q) begin
            act_d = sh_q;
            ack_d = req_s2_q;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_q) begin
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
            ack_q    <= 1'b0;
            act_q    <= '{power: ACT_PWR_NORMAL, test: ACT_TEST_RESET,
                          offset: ACT_OFFSET_RESET};
        end else begin
            req_s1_q <= req_q;
            req_s2_q <= req_s1_q;
            ack_q    <= ack_d;
            act_q    <= act_d;
        end
    end

    // ----------------------------------------------------------------
    // Power mode decode
    // ----------------------------------------------------------------
    logic running;
    logic dp_hold;

    assign power_down_out   = (act_q.power == ACT_PWR_DOWN);
    assign dp_clk_en_out    = (act_q.power == ACT_PWR_NORMAL) ||
                              (act_q.power == ACT_PWR_DPRESET);
    assign dp_reset_out     = (act_q.power == ACT_PWR_DPRESET);
    assign serial_reset_out = (act_q.power == ACT_PWR_DPRESET);
    assign outputs_en_out   = (act_q.power != ACT_PWR_DOWN);
    assign running          = (act_q.power == ACT_PWR_NORMAL);
    assign dp_hold          = (act_q.power == ACT_PWR_DPRESET);

    // ----------------------------------------------------------------
    // Test pattern generator and offset adder
    // ----------------------------------------------------------------
    logic              fifo_ready;
    logic              accept;
    logic [22:0]       pn_q, pn_d;
    logic [DATA_W-1:0] ramp_q, ramp_d;
    logic              tog_q, tog_d;
    logic [1:0]        uix_q, uix_d;
    logic              udone_q, udone_d;
    logic [DATA_W-1:0] gen;
    logic [DATA_W:0]   sum;
    logic [DATA_W-1:0] adj;
    logic [DATA_W-1:0] uword [4];
    logic [3:0]        mode;

    localparam logic [DATA_W:0] SAT_MAX = {2'b00, {(DATA_W-1){1'b1}}};
    localparam logic [DATA_W:0] SAT_MIN = {2'b11, {(DATA_W-1){1'b0}}};

    // Unpack the four user words
    for (genvar i = 0; i < 4; i++) begin : g_user
        assign uword[i] = user_pattern_in[i*DATA_W +: DATA_W];
    end

    assign mode             = act_q.test[3:0];
    assign accept           = sample_valid_in && fifo_ready && running;
    assign sample_ready_out = fifo_ready && running;

    // Offset adds to converter data with saturation
    always_comb begin
        sum = {sample_data_in[DATA_W-1], sample_data_in} +
              {{(DATA_W-5){act_q.offset[5]}}, act_q.offset};
        if ($signed(sum) > $signed(SAT_MAX)) begin
            adj = SAT_MAX[DATA_W-1:0];
        end else if ($signed(sum) < $signed(SAT_MIN)) begin
            adj = SAT_MIN[DATA_W-1:0];
        end else begin
            adj = sum[DATA_W-1:0];
        end
    end

    // Output source select
    always_comb begin
        case (mode)
            ACT_TG_OFF:     gen = adj;
            ACT_TG_MID:     gen = '0;
            ACT_TG_POSFS:   gen = {1'b0, {(DATA_W-1){1'b1}}};
            ACT_TG_NEGFS:   gen = {1'b1, {(DATA_W-1){1'b0}}};
            ACT_TG_CHECKER: gen = {(DATA_W/2){tog_q, !tog_q}};
            ACT_TG_PN_LONG: gen = pn_q[DATA_W-1:0];
            ACT_TG_TOGGLE:  gen = {DATA_W{tog_q}};
            ACT_TG_USER:    gen = udone_q ? '0 : uword[uix_q];
            ACT_TG_RAMP:    gen = ramp_q;
            default:        gen = '0;
        endcase
    end

    // Generator state advances once per accepted sample
    always_comb begin
        pn_d    = pn_q;
        ramp_d  = ramp_q;
        tog_d   = tog_q;
        uix_d   = uix_q;
        udone_d = udone_q;
        if (accept) begin
            pn_d   = {pn_q[21:0], pn_q[22] ^ pn_q[ACT_PN_TAP]};
            ramp_d = ramp_q + 1'b1;
            tog_d  = !tog_q;
            uix_d  = uix_q + 2'h1;
            if (uix_q == 2'h3 && act_q.test[ACT_TEST_ONCE_BIT]) begin
                udone_d = 1'b1;
            end
        end
        if (mode != ACT_TG_USER) begin
            uix_d   = 2'h0;
            udone_d = 1'b0;
        end
        if (act_q.test[ACT_TEST_PNRST_BIT]) begin
            pn_d = ACT_PN_SEED;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_q || dp_hold) begin
            pn_q    <= ACT_PN_SEED;
            ramp_q  <= '0;
            tog_q   <= 1'b0;
            uix_q   <= 2'h0;
            udone_q <= 1'b0;
        end else begin
            pn_q    <= pn_d;
            ramp_q  <= ramp_d;
            tog_q   <= tog_d;
            uix_q   <= uix_d;
            udone_q <= udone_d;
        end
    end

    // ----------------------------------------------------------------
    // Output buffer
    // ----------------------------------------------------------------
    act_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_in        (core_clk_in),
        .nrst_in       (rst_n_q),
        .in_valid_in   (accept),
        .in_ready_out  (fifo_ready),
        .in_data_in    (gen),
        .out_valid_out (out_valid_out),
        .out_ready_in  (out_ready_in),
        .out_data_out  (out_data_out)
    );
endmodule // act_regs

`default_nettype wire

/* File: verification/act_regs_properties.sv */
/* Port checker for the register bank top.
   Assumes binding to act_regs; sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module act_regs_properties
    import act_pkg::*;
#(
    parameter int DATA_W = 12
) (
    input wire logic              core_clk_in,
    input wire logic              nrst_in,
    input wire logic              csb_n_in,
    input wire logic              sdio_oe_out,
    input wire logic              power_down_out,
    input wire logic              dp_clk_en_out,
    input wire logic              dp_reset_out,
    input wire logic              serial_reset_out,
    input wire logic              outputs_en_out,
    input wire logic              sample_valid_in,
    input wire logic              sample_ready_out,
    input wire logic              out_valid_out,
    input wire logic              out_ready_in,
    input wire logic [DATA_W-1:0] out_data_out
);
    // -----------------------------------------------------------
    // Power and stream relations
    // -----------------------------------------------------------
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!nrst_in);
    a_down_quiet: assert property (power_down_out |-> !outputs_en_out && !dp_clk_en_out
        && !dp_reset_out) else $error("power down outputs wrong");
    a_standby_hold: assert property (!dp_clk_en_out && !power_down_out |-> outputs_en_out
        && !dp_reset_out && !sample_ready_out) else $error("standby wrong");
    a_dpreset_pair: assert property (dp_reset_out |-> serial_reset_out && dp_clk_en_out
        && outputs_en_out && !sample_ready_out) else $error("reset mode wrong");
    a_outen_link: assert property (outputs_en_out != power_down_out)
        else $error("output enable wrong");
    a_push_shows: assert property (sample_valid_in && sample_ready_out |=> out_valid_out)
        else $error("pushed word missing");
    a_head_stable: assert property (out_valid_out && !out_ready_in |=> out_valid_out
        && $stable(out_data_out)) else $error("head word moved");
    a_oe_idle: assert property (csb_n_in [*2] |-> !sdio_oe_out)
        else $error("sdio driven while idle");
    a_reset_quiet: assert property ($rose(nrst_in) |-> !out_valid_out && !power_down_out)
        else $error("state after reset wrong");
endmodule // act_regs_properties
bind act_regs act_regs_properties #(.DATA_W(DATA_W)) i_act_regs_properties (
    .core_clk_in(core_clk_in), .nrst_in(nrst_in), .csb_n_in(csb_n_in),
    .sdio_oe_out(sdio_oe_out), .power_down_out(power_down_out),
    .dp_clk_en_out(dp_clk_en_out), .dp_reset_out(dp_reset_out),
    .serial_reset_out(serial_reset_out), .outputs_en_out(outputs_en_out),
    .sample_valid_in(sample_valid_in), .sample_ready_out(sample_ready_out),
    .out_valid_out(out_valid_out), .out_ready_in(out_ready_in), .out_data_out(out_data_out));
`default_nettype wire

/* File: verification/act_host.sv */
/* Serial host model for the register bank.
   Assumes the bench resolves nothing else on the data line. */
`timescale 1ns/1ps
`default_nettype none
module act_host (
    output logic      sclk_out,
    output logic      csb_n_out,
    output logic      sdio_out,
    input  wire logic dev_d_in,
    input  wire logic dev_oe_in
);
    logic h_d;
    logic h_oe;
    // Released line shows the inverse of the last bit
    assign sdio_out = dev_oe_in ? dev_d_in : (h_oe ? h_d : !h_d);
    initial begin
        sclk_out = 1'b0;
        csb_n_out = 1'b1;
        h_d = 1'b0;
        h_oe = 1'b1;
    end
    // One frame, one byte; clock stands still between frames
    task automatic frame(input logic rd, input logic [12:0] a, input logic [7:0] d,
                         output logic [7:0] q);
        logic [23:0] sh;
        sh = {rd, 2'b00, a, d};
        q = 8'h00;
        #3 csb_n_out = 1'b0;
        for (int i = 0; i < 24; i++) begin
            h_d = sh[23-i];
            h_oe = !(rd && i >= 16);
            #15;
            if (i >= 16) q[23-i] = sdio_out;
            sclk_out = 1'b1;
            #15 sclk_out = 1'b0;
        end
        #15 csb_n_out = 1'b1;
        h_oe = 1'b1;
        #30;
    endtask
endmodule // act_host
`default_nettype wire

/* File: verification/act_regs_test.sv */
/* Self-checking bench for the register bank.
   Assumes act_host as serial partner and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module act_regs_test;
    import act_pkg::*;
    localparam logic [7:0]  CHIP_IDENTITY = 8'h3C; // Arbitrary value
    localparam logic [1:0]  GRADE   = 2'h1;  // Arbitrary value
    localparam logic [47:0] USER    = 48'h444333222111;
    localparam logic [7:0]  CODES [11] = '{8'h81, 8'h02, 8'h03, 8'h84, 8'h25,
                                           8'h07, 8'h06, 8'h09, 8'h08, 8'h88, 8'h05};
    logic core_clk = 1'b0, nrst = 1'b0, pll = 1'b0, sv = 1'b0, ordy = 1'b0;
    logic [11:0] sd = 12'h000;
    wire logic sclk, csb_n, sdio, sdo, sdo_oe, pd, clken, dprst, srst, oen, srdy, ovld;
    wire logic [11:0] odata;
    int n_errors = 0, total_checks = 0, cycles = 0;
    act_regs #(.CHIP_IDENTITY(CHIP_IDENTITY), .GRADE(GRADE)) i_act_regs (.core_clk_in(core_clk),
        .nrst_in(nrst), .sclk_in(sclk), .csb_n_in(csb_n), .sdio_in(sdio), .sdio_out(sdo),
        .sdio_oe_out(sdo_oe), .pll_locked_in(pll), .power_down_out(pd), .dp_clk_en_out(clken),
        .dp_reset_out(dprst), .serial_reset_out(srst), .outputs_en_out(oen),
        .sample_valid_in(sv), .sample_ready_out(srdy), .sample_data_in(sd),
        .user_pattern_in(USER), .out_valid_out(ovld), .out_ready_in(ordy), .out_data_out(odata));
    act_host i_act_host (.sclk_out(sclk), .csb_n_out(csb_n), .sdio_out(sdio),
        .dev_d_in(sdo), .dev_oe_in(sdo_oe));
    // Core clock and hang limit
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 30000) begin
            n_errors++;
            give_verdict;
        end
    end
    task automatic check(input logic [11:0] got, input logic [11:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic give_verdict;
        $display("checks=%0d errors=%0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        logic [7:0] q;
        i_act_host.frame(1'b0, a, d, q);
    endtask
    task automatic rd(input logic [12:0] a, input logic [7:0] e);
        logic [7:0] q;
        i_act_host.frame(1'b1, a, 8'h00, q);
        check({4'h0, q}, {4'h0, e});
    endtask
    task automatic commit;
        wr(ACT_ADDR_TRANSFER, ACT_TRANSFER_GO);
        repeat (10) @(posedge core_clk);
    endtask
    task automatic do_reset;
        @(posedge core_clk);
        nrst <= 1'b0;
        repeat (3) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge core_clk);
    endtask
    // Expected power outputs with an empty buffer
    function automatic logic [11:0] pw(input logic [1:0] m);
        return {6'h00, m == 2'h1, m == 2'h0 || m == 2'h3, m == 2'h3, m == 2'h3, m != 2'h1,
                m == 2'h0};
    endfunction
    // Expected output word k for one test setting
    function automatic logic [11:0] pat(input logic [7:0] t, input logic [5:0] o,
                                        input logic [11:0] s, input int k);
        logic [12:0] y;
        y = {s[11], s} + {{7{o[5]}}, o};
        case (t[3:0])
            4'h0: return (y[12] != y[11]) ? (y[12] ? 12'h800 : 12'h7FF) : y[11:0];
            4'h2: return 12'h7FF;
            4'h3: return 12'h800;
            4'h4: return k[0] ? 12'hAAA : 12'h555;
            4'h5: return 12'hFFF << (t[5] ? 0 : k);
            4'h7: return k[0] ? 12'hFFF : 12'h000;
            4'h8: return (t[7] && k > 3) ? 12'h000 : USER[12*(k%4) +: 12];
            4'hF: return 12'(k);
            default: return 12'h000;
        endcase
    endfunction
    task automatic t_regs;
        rd(ACT_ADDR_CHIP_IDENTITY, CHIP_IDENTITY);
        rd(ACT_ADDR_GRADE, {2'b00, GRADE, 4'h0});
        rd(ACT_ADDR_POWER, ACT_POWER_RESET);
        rd(ACT_ADDR_TEST, ACT_TEST_RESET);
        wr(ACT_ADDR_CHIP_IDENTITY, 8'hFF);
        rd(ACT_ADDR_CHIP_IDENTITY, CHIP_IDENTITY);
        rd(13'h0003, 8'h00);
        rd(ACT_ADDR_PLL, 8'h00);
        @(posedge core_clk);
        pll <= 1'b1;
        rd(ACT_ADDR_PLL, 8'h80);
    endtask
    task automatic t_power;
        logic [1:0] m;
        logic [1:0] prev;
        prev = 2'h0;
        for (int i = 3; i >= 0; i--) begin
            m = 2'(i);
            wr(ACT_ADDR_POWER, {6'h20, m});
            rd(ACT_ADDR_POWER, {6'h20, m});
            check({6'h00, pd, clken, dprst, srst, oen, srdy}, pw(prev));
            commit;
            check({6'h00, pd, clken, dprst, srst, oen, srdy}, pw(m));
            prev = m;
        end
        rd(ACT_ADDR_TRANSFER, 8'h00);
    endtask
    task automatic t_pat(input logic [7:0] t, input logic [5:0] o, input logic [11:0] s);
        do_reset;
        wr(ACT_ADDR_TEST, t);
        wr(ACT_ADDR_OFFSET, {2'b00, o});
        commit;
        for (int k = 0; k < 6; k++) begin
            @(posedge core_clk);
            sv <= 1'b1;
            sd <= s;
            @(posedge core_clk);
            sv <= 1'b0;
            for (int w = 0; w < 4 && ovld !== 1'b1; w++) @(posedge core_clk) #1;
            check(odata ^ {12{!ovld}}, pat(t, o, s, k));
            @(posedge core_clk);
            ordy <= 1'b1;
            @(posedge core_clk);
            ordy <= 1'b0;
        end
    endtask
    task automatic t_fill;
        do_reset;
        wr(ACT_ADDR_TEST, {4'h0, ACT_TG_RAMP});
        commit;
        @(posedge core_clk);
        sv <= 1'b1;
        repeat (20) @(posedge core_clk);
        sv <= 1'b0;
        #1 check({10'h000, srdy, ovld}, 12'h001);
        @(posedge core_clk);
        ordy <= 1'b1;
        for (int k = 0; k < 16; k++) begin
            #1 check(odata, 12'(k));
            @(posedge core_clk);
        end
        ordy <= 1'b0;
        #1 check({11'h000, ovld}, 12'h000);
    endtask
    // Main sequence
    initial begin
        do_reset;
        t_regs;
        t_power;
        t_pat(8'h00, 6'h3F, 12'h100);
        t_pat(8'h00, 6'h1F, 12'h7F0);
        t_pat(8'h00, 6'h20, 12'h810);
        foreach (CODES[j]) t_pat(CODES[j], 6'h00, 12'h000);
        t_fill;
        give_verdict;
    end
endmodule // act_regs_test
`default_nettype wire
